// [hdl/csc_map.vh]
/*
  Register map, field positions, codes and reset values of the capacitive-sense
  control block. Assumes it is included by bare name from the design file.
*/
`ifndef CSC_MAP_VH
`define CSC_MAP_VH

`define CSC_ADDR_CONFIG   8'haa
`define CSC_ADDR_CONTROL  8'hb0
`define CSC_RESET_CONFIG  8'h00
`define CSC_RESET_CONTROL 8'h00

`define CSC_CN_ENABLE     7
`define CSC_CN_EOS        6
`define CSC_CN_DONE       5
`define CSC_CN_BUSY       4
`define CSC_CN_CMPEN      3
`define CSC_CN_PME        1
`define CSC_CN_TRIP       0

`define CSC_CF_SMEN       7
`define CSC_CF_MODE_HI    6
`define CSC_CF_MODE_LO    4
`define CSC_CF_MCEN       3
`define CSC_CF_ACU_HI     2
`define CSC_CF_ACU_LO     0

`define CSC_MODE_SW       3'h0
`define CSC_MODE_TMR0     3'h1
`define CSC_MODE_TMR2     3'h2
`define CSC_MODE_TMR1     3'h3
`define CSC_MODE_TMR3     3'h4
`define CSC_MODE_SINGLE   3'h5
`define CSC_MODE_CONT     3'h6
`define CSC_MODE_SCAN     3'h7

`define CSC_CHANNELS      14

`endif

// [hdl/csc_ctrl.v]
/*
  Control and configuration logic of the capacitive-sense converter: the control
  and configuration registers on the special-function-register bus, start trigger
  selection, sample accumulation and averaging, the threshold comparator, channel
  stepping for scans and the sticky status flags.
  Assumes a front end that answers each start pulse with one sample_valid_i pulse
  some cycles later, and that the data, threshold, mask and scan-range registers
  live elsewhere and arrive here as plain levels.
*/
`include "csc_map.vh"

module csc_ctrl (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire        sfr_wr_i,
  input  wire [7:0]  sfr_wdata_i,
  output wire [7:0]  sfr_rdata_o,
  input  wire [3:0]  timer_ovf_i,
  input  wire        retry_i,
  input  wire        sample_valid_i,
  input  wire [15:0] sample_i,
  input  wire [15:0] threshold_i,
  input  wire [13:0] scan_mask_i,
  input  wire [4:0]  scan_start_i,
  input  wire [4:0]  scan_end_i,
  output wire        converter_enable_o,
  output wire        sample_start_o,
  output wire [4:0]  channel_o,
  output wire        multi_channel_o,
  output wire [13:0] channel_mask_o,
  output wire [15:0] result_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  reg  [7:0]  config_q;
  reg  [7:0]  config_d;
  reg         enable_q;
  reg         cmpen_q;
  reg         eos_q;
  reg         done_q;
  reg         pme_q;
  reg         trip_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         run_q;
  reg         run_d;
  reg         halt_q;
  reg         halt_d;
  reg  [21:0] acc_q;
  reg  [21:0] acc_d;
  reg  [6:0]  cnt_q;
  reg  [6:0]  cnt_d;
  reg  [4:0]  chan_q;
  reg  [4:0]  chan_d;
  reg  [15:0] result_q;
  reg  [15:0] result_d;
  reg         start_q;
  reg         start_d;
  reg  [7:0]  rdata_q;
  reg         single_q;
  reg         set_eos;
  reg         set_done;
  reg         set_trip;

  wire [2:0] mode  = config_q[`CSC_CF_MODE_HI:`CSC_CF_MODE_LO];
  wire [2:0] acu   = config_q[`CSC_CF_ACU_HI:`CSC_CF_ACU_LO];
  wire       smen  = config_q[`CSC_CF_SMEN];
  wire       wr_cn = sfr_wr_i && (sfr_addr_i == `CSC_ADDR_CONTROL);
  wire       wr_cf = sfr_wr_i && (sfr_addr_i == `CSC_ADDR_CONFIG);

  // Returns the sample count minus one; zero also for reserved codes.
  function [6:0] depth_of;
    input [2:0] code;
    begin
      case (code)
        3'h1:    depth_of = 7'h03;
        3'h2:    depth_of = 7'h07;
        3'h3:    depth_of = 7'h0f;
        3'h4:    depth_of = 7'h1f;
        3'h5:    depth_of = 7'h3f;
        default: depth_of = 7'h00;
      endcase
    end
  endfunction

  // Divide by the sample count; every count is a power of two.
  function [15:0] average;
    input [2:0]  code;
    input [21:0] sum;
    begin
      case (code)
        3'h1:    average = sum[17:2];
        3'h2:    average = sum[18:3];
        3'h3:    average = sum[19:4];
        3'h4:    average = sum[20:5];
        3'h5:    average = sum[21:6];
        default: average = sum[15:0];
      endcase
    end
  endfunction

  // Next scan channel: {wrapped past end, channel}. Unmasked channels are
  // skipped only while masking is on; 32 steps cover every channel code.
  function [5:0] next_chan;
    input [4:0]  cur;
    input [4:0]  first;
    input [4:0]  last;
    input [13:0] mask;
    input        use_mask;
    reg   [4:0]  c;
    reg          wrap;
    reg          found;
    integer      k;
    begin
      c = cur;
      wrap = 1'b0;
      found = 1'b0;
      next_chan = {1'b0, cur};
      for (k = 0; k < 32; k = k + 1) begin
        if (!found) begin
          if (c == last) begin
            c = first;
            wrap = 1'b1;
          end else begin
            c = c + 5'd1;
          end
          if (!use_mask || ((c < `CSC_CHANNELS) && mask[c[3:0]])) begin
            found = 1'b1;
            next_chan = {wrap, c};
          end
        end
      end
    end
  endfunction

  wire       reserved  = (acu[2:1] == 2'b11) ||
                         ((mode == `CSC_MODE_SINGLE) && !smen);
  wire       scan_mode = (mode == `CSC_MODE_SCAN) || (mode == `CSC_MODE_SINGLE);
  wire       sw_start  = wr_cn && sfr_wdata_i[`CSC_CN_BUSY] &&
                         ((mode == `CSC_MODE_SW) || (mode == `CSC_MODE_CONT) ||
                          (mode == `CSC_MODE_SCAN));
  reg        tmr_hit;
  // A single scan is armed by the configuration write and launched one cycle later,
  // once the new mode, mask enable and depth stand in the register.
  wire       single_go = single_q && (mode == `CSC_MODE_SINGLE) && smen;
  wire [5:0] nxt       = next_chan(chan_q, scan_start_i, scan_end_i, scan_mask_i, smen);
  // Scans begin at the first included channel, so an excluded start channel is
  // never converted.
  wire [5:0] head      = next_chan(scan_end_i, scan_start_i, scan_end_i, scan_mask_i, smen);
  wire [15:0] avg      = average(acu, acc_q + {6'h00, sample_i});
  wire       exceed    = cmpen_q && (avg > threshold_i);

  always @* begin
    case (mode)
      `CSC_MODE_TMR0: tmr_hit = timer_ovf_i[0];
      `CSC_MODE_TMR2: tmr_hit = timer_ovf_i[2];
      `CSC_MODE_TMR1: tmr_hit = timer_ovf_i[1];
      `CSC_MODE_TMR3: tmr_hit = timer_ovf_i[3];
      default:        tmr_hit = 1'b0;
    endcase
  end

  always @* begin
    state_d  = state_q;
    run_d    = run_q;
    halt_d   = halt_q;
    acc_d    = acc_q;
    cnt_d    = cnt_q;
    chan_d   = chan_q;
    result_d = result_q;
    start_d  = 1'b0;
    set_eos  = 1'b0;
    set_done = 1'b0;
    set_trip = 1'b0;
    if (sw_start) begin
      halt_d = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        if (enable_q && !reserved &&
            (tmr_hit || (sw_start && !halt_q) || (sw_start && halt_q) ||
             (single_go && smen))) begin
          state_d = ST_CONV;
          start_d = 1'b1;
          acc_d   = 22'h00_0000;
          cnt_d   = 7'h00;
          run_d   = (mode == `CSC_MODE_CONT) || scan_mode;
          halt_d  = 1'b0;
          if (scan_mode && (sw_start || single_go)) begin
            chan_d = head[4:0];
          end
        end
      end
      ST_CONV: begin
        if (!enable_q) begin
          state_d = ST_IDLE;
          run_d   = 1'b0;
        end else if (sample_valid_i) begin
          if (cnt_q != depth_of(acu)) begin
            acc_d   = acc_q + {6'h00, sample_i};
            cnt_d   = cnt_q + 7'd1;
            start_d = 1'b1;
          end else begin
            result_d = avg;
            set_done = 1'b1;
            set_trip = exceed;
            acc_d    = 22'h00_0000;
            cnt_d    = 7'h00;
            if (scan_mode && exceed) begin
              halt_d  = 1'b1;
              run_d   = 1'b0;
              state_d = ST_IDLE;
            end else if (scan_mode) begin
              chan_d  = nxt[4:0];
              set_eos = nxt[5];
              if (nxt[5] && (mode == `CSC_MODE_SINGLE)) begin
                run_d   = 1'b0;
                state_d = ST_IDLE;
              end else begin
                start_d = 1'b1;
              end
            end else if (run_q && (mode == `CSC_MODE_CONT)) begin
              start_d = 1'b1;
            end else begin
              run_d   = 1'b0;
              state_d = ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @* begin
    config_d = config_q;
    if (wr_cf) begin
      config_d = sfr_wdata_i;
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_q <= `CSC_RESET_CONFIG;
      enable_q <= 1'b0;
      cmpen_q  <= 1'b0;
      eos_q    <= 1'b0;
      done_q   <= 1'b0;
      pme_q    <= 1'b0;
      trip_q   <= 1'b0;
      state_q  <= ST_IDLE;
      run_q    <= 1'b0;
      halt_q   <= 1'b0;
      acc_q    <= 22'h00_0000;
      cnt_q    <= 7'h00;
      chan_q   <= 5'h00;
      result_q <= 16'h0000;
      start_q  <= 1'b0;
      rdata_q  <= 8'h00;
      single_q <= 1'b0;
    end else begin
      single_q <= wr_cf &&
                  (sfr_wdata_i[`CSC_CF_MODE_HI:`CSC_CF_MODE_LO] == `CSC_MODE_SINGLE);
      config_q <= config_d;
      state_q  <= state_d;
      run_q    <= run_d;
      halt_q   <= halt_d;
      acc_q    <= acc_d;
      cnt_q    <= cnt_d;
      chan_q   <= chan_d;
      result_q <= result_d;
      start_q  <= start_d;
      if (wr_cn) begin
        enable_q <= sfr_wdata_i[`CSC_CN_ENABLE];
        cmpen_q  <= sfr_wdata_i[`CSC_CN_CMPEN];
      end
      // Hardware sets win over a software clear in the same cycle.
      eos_q  <= set_eos  | (eos_q  & ~(wr_cn & ~sfr_wdata_i[`CSC_CN_EOS]));
      done_q <= set_done | (wr_cn ? sfr_wdata_i[`CSC_CN_DONE] : done_q);
      pme_q  <= retry_i  | (pme_q  & ~(wr_cn & ~sfr_wdata_i[`CSC_CN_PME]));
      trip_q <= set_trip | (trip_q & ~(wr_cn & ~sfr_wdata_i[`CSC_CN_TRIP]));
      case (sfr_addr_i)
        `CSC_ADDR_CONTROL: rdata_q <= {enable_q, eos_q, done_q, state_q[1] & enable_q,
                                       cmpen_q, 1'b0, pme_q, trip_q};
        `CSC_ADDR_CONFIG:  rdata_q <= config_q;
        default:           rdata_q <= 8'h00;
      endcase
    end
  end

  reg        mc_q;
  reg [13:0] mask_q;

  // Masks are forwarded only when masking is on, so a stale mask cannot steer
  // the front end while it is meant to be ignored.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mc_q   <= 1'b0;
      mask_q <= 14'h0000;
    end else begin
      mc_q   <= enable_q & config_q[`CSC_CF_MCEN];
      mask_q <= smen ? scan_mask_i : 14'h0000;
    end
  end

  assign sfr_rdata_o        = rdata_q;
  assign converter_enable_o = enable_q;
  assign sample_start_o     = start_q;
  assign channel_o          = chan_q;
  assign multi_channel_o    = mc_q;
  assign channel_mask_o     = mask_q;
  assign result_o           = result_q;

endmodule // csc_ctrl

// [test/csc_ctrl_sva.sv]
/*
  Port-level assertions for the capacitive-sense control block.
  Assumes one clock domain and an active-low asynchronous reset.
*/
module csc_ctrl_sva (
  input wire        clk_i,
  input wire        rstn_i,
  input wire [7:0]  sfr_addr_i,
  input wire        sfr_wr_i,
  input wire [7:0]  sfr_wdata_i,
  input wire [7:0]  sfr_rdata_o,
  input wire        sample_valid_i,
  input wire [13:0] scan_mask_i,
  input wire        converter_enable_o,
  input wire        sample_start_o,
  input wire [13:0] channel_mask_o,
  input wire [15:0] result_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire wr_ctl = sfr_wr_i && sfr_addr_i == 8'hb0;
  wire wr_cfg = sfr_wr_i && sfr_addr_i == 8'haa;
  a_start_one_cycle: assert property (sample_start_o |=> !sample_start_o)
    else $error("start pulse longer than one cycle");
  a_off_no_start: assert property
    (!converter_enable_o && !$past(converter_enable_o) |-> !sample_start_o)
    else $error("start while disabled");
  a_enable_follows: assert property
    (wr_ctl |=> converter_enable_o == $past(sfr_wdata_i[7]))
    else $error("enable output does not follow write");
  a_busy_needs_enable: assert property
    ($past(sfr_addr_i) == 8'hb0 && sfr_rdata_o[4] |-> $past(converter_enable_o))
    else $error("busy while disabled");
  a_unmapped_zero: assert property
    ($past(sfr_addr_i) != 8'haa && $past(sfr_addr_i) != 8'hb0 |-> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_result_cause: assert property ($changed(result_o) |-> $past(sample_valid_i))
    else $error("result changed without sample");
  a_mask_gate: assert property
    (channel_mask_o == 14'h0 || channel_mask_o == $past(scan_mask_i))
    else $error("mask output not from mask input");
  a_mask_off: assert property
    (wr_cfg && !sfr_wdata_i[7] ##1 !wr_cfg |=> channel_mask_o == 14'h0)
    else $error("mask output not cleared");
  c_result: cover property (sample_valid_i ##1 $changed(result_o));
  c_busy_write: cover property (wr_ctl && sfr_wdata_i[4]);
  c_mask_on: cover property (channel_mask_o != 14'h0);
endmodule // csc_ctrl_sva

bind csc_ctrl csc_ctrl_sva sva_u (.clk_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
  .sfr_rdata_o, .sample_valid_i, .scan_mask_i, .converter_enable_o, .sample_start_o,
  .channel_mask_o, .result_o);

// [test/csc_ctrl_tb.sv]
/*
  Self-checking bench for the capacitive-sense control block.
  Assumes the bench stands in for the register bus, timers and front end.
*/
module csc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 0, rstn_i = 0, sfr_wr_i = 0, retry_i = 0, sample_valid_i = 0;
  logic [7:0]  sfr_addr_i = 0, sfr_wdata_i = 0;
  logic [3:0]  timer_ovf_i = 0;
  logic [15:0] sample_i = 0, threshold_i = 16'hffff;
  logic [13:0] scan_mask_i = 0;
  logic [4:0]  scan_start_i = 0, scan_end_i = 0;
  wire  [7:0]  sfr_rdata_o;
  wire         converter_enable_o, sample_start_o, multi_channel_o;
  wire  [4:0]  channel_o;
  wire  [13:0] channel_mask_o;
  wire  [15:0] result_o;
  int          mismatches = 0, comparisons = 0;
  int          starts = 0, used = 0;
  csc_ctrl dut_u (.clk_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
    .timer_ovf_i, .retry_i, .sample_valid_i, .sample_i, .threshold_i, .scan_mask_i,
    .scan_start_i, .scan_end_i, .converter_enable_o, .sample_start_o, .channel_o,
    .multi_channel_o, .channel_mask_o, .result_o);
  initial forever #2 clk_i = ~clk_i;
  // Start pulses are counted as they stand, so a pulse launched by the write edge is not lost.
  always @(posedge clk_i) begin
    if (sample_start_o === 1'b1) starts++;
  end
  task automatic final_report;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    used = starts;
    sfr_addr_i = a; sfr_wdata_i = d; sfr_wr_i = 1; tick(); sfr_wr_i = 0; tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    sfr_addr_i = a; tick(2); cmp(sfr_rdata_o & m, e);
  endtask
  // A missing start pulse ends the run, since nothing after it can be trusted.
  task automatic wst(input logic e);
    for (int i = 0; i < 40 && starts == used; i++) tick();
    cmp(starts != used, e);
    if (e && starts == used) final_report();
    used = starts;
  endtask
  task automatic smp(input logic [15:0] v, input logic [4:0] ch);
    wst(1'b1);
    cmp(channel_o, ch);
    cmp(sfr_rdata_o[4], 1'b1);
    tick(); sample_i = v; sample_valid_i = 1; tick(); sample_valid_i = 0; tick(2);
  endtask
  task automatic s_regs;
    rd(8'haa, 8'hff, 8'h00);
    rd(8'hb0, 8'hff, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'hff, 8'h00);
    rd(8'hb0, 8'hff, 8'h00);
  endtask
  task automatic s_acc;
    int sum, n;
    wr(8'hb0, 8'h80);
    for (int k = 0; k < 6; k++) begin
      n = (k == 0) ? 1 : (2 << k);
      sum = 0;
      wr(8'haa, k[7:0]); wr(8'hb0, 8'h90);
      for (int j = 0; j < n; j++) begin
        smp(16'h1230 + j[15:0], 5'h0); sum += 16'h1230 + j;
      end
      cmp(result_o, sum / n);
      rd(8'hb0, 8'h30, 8'h20);
    end
  endtask
  task automatic s_cmp;
    threshold_i = 16'h1000;
    wr(8'haa, 8'h00); wr(8'hb0, 8'h98); smp(16'h1000, 5'h0);
    rd(8'hb0, 8'h01, 8'h00);
    wr(8'hb0, 8'h98); smp(16'h1001, 5'h0);
    rd(8'hb0, 8'h31, 8'h21);
    wr(8'hb0, 8'h89);
    rd(8'hb0, 8'h21, 8'h01);
    wr(8'hb0, 8'h90); smp(16'hffff, 5'h0);
    rd(8'hb0, 8'h01, 8'h00);
  endtask
  task automatic s_reserved;
    wr(8'haa, 8'h06); wr(8'hb0, 8'h90); wst(1'b0);
    wr(8'haa, 8'h50); wr(8'hb0, 8'h90); wst(1'b0);
  endtask
  task automatic s_timer;
    int b;
    for (int m = 1; m < 5; m++) begin
      b = (m == 1) ? 0 : (m == 2) ? 2 : (m == 3) ? 1 : 3;
      wr(8'haa, m[3:0] << 4); wr(8'hb0, 8'h90);
      timer_ovf_i = ~(4'h1 << b); tick(); timer_ovf_i = 0;
      wst(1'b0);
      timer_ovf_i = 4'h1 << b; tick(); timer_ovf_i = 0;
      smp(16'h0, 5'h0);
    end
  endtask
  task automatic s_scan;
    scan_start_i = 5'h2; scan_end_i = 5'h3; threshold_i = 16'hffff;
    wr(8'haa, 8'h70); wr(8'hb0, 8'h90);
    smp(16'h0, 5'h2);
    smp(16'h0, 5'h3);
    smp(16'h0, 5'h2);
    rd(8'hb0, 8'h40, 8'h40);
    rd(8'hb0, 8'h40, 8'h40);
    wr(8'hb0, 8'h00); threshold_i = 16'h0; wr(8'hb0, 8'h80); wr(8'hb0, 8'h98);
    smp(16'h0001, 5'h2); wst(1'b0);
    cmp(channel_o, 5'h2);
  endtask
  task automatic s_modes;
    wr(8'haa, 8'h60); wr(8'hb0, 8'h90);
    smp(16'h0, 5'h2);
    smp(16'h0, 5'h2);
    wr(8'hb0, 8'h00); wr(8'hb0, 8'h80);
    scan_start_i = 5'h2; scan_end_i = 5'h5; scan_mask_i = 14'h0028;
    wr(8'haa, 8'hd0); sfr_addr_i = 8'hb0;
    smp(16'h0, 5'h3);
    smp(16'h0, 5'h5);
    wst(1'b0);
    rd(8'hb0, 8'h50, 8'h40);
    cmp(channel_o, 5'h3);
  endtask
  task automatic s_misc;
    wr(8'hb0, 8'h80); retry_i = 1; tick(); retry_i = 0;
    rd(8'hb0, 8'h02, 8'h02);
    wr(8'hb0, 8'h82);
    rd(8'hb0, 8'h02, 8'h02);
    wr(8'hb0, 8'h80);
    rd(8'hb0, 8'h02, 8'h00);
    scan_mask_i = 14'h0a5a; wr(8'haa, 8'h88); tick(2);
    cmp(channel_mask_o, 14'h0a5a);
    cmp(multi_channel_o, 1'b1);
    wr(8'haa, 8'h00); tick();
    cmp(channel_mask_o, 14'h0000);
    cmp(multi_channel_o, 1'b0);
    wr(8'hb0, 8'h00); tick(2);
    cmp(converter_enable_o, 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rstn_i = 1;
    s_regs(); s_acc(); s_cmp(); s_reserved(); s_timer(); s_scan(); s_modes(); s_misc();
    final_report();
  end
endmodule // csc_ctrl_tb
